// ---- core/smv_serial_regs.v ----
// Purpose: Serial mode and master volume register bank with the serial
//          framing, filter clock divider and interrupt gating it steers.
// Assumes: Host reaches registers by an index port and a data port; all
//          link pins are asynchronous and are sampled on i_clk.
// Notes:   Internal sample words are two's complement, MSB aligned.
//
// Contract
// - Output override in serial mode takes volume from low four bits.
// - Speaker source field applies in every mode, with code 111 forced to mute code 000; 001-011 duplex monitors.
// - Analog override makes low six bits effective only in serial mode.
// - Direction bit one means ADC, zero means DAC, per channel.
// - Duplex output to right filter pin, duplex input to left ADC.
// - Force bit sets serial mode; otherwise serial mode follows the pin.
// - Format bit set means two's complement data, clear means unsigned.
// - Serial reset clears toggles, blocks duplex output, zeroes shifters.
// - Synth enable lets external synth take FM DACs on activity.
// - Polarity bit set makes both frame syncs active low.
// - Filter override in serial mode divides serial clock for filter clock.
// - Low nibble is negative divisor; 02h divides by fourteen.
// - Transmit source: zero code, FIFO, left or stereo ADC, right ADC.
// - Word length is sixteen bits when length bit set, else eight.
// - Stereo words alternate channels, left before right.
// - Receive target: zero, FIFO, DAC, FM DAC; mono right data, left complement.
// - Volume counters hold mute bit six, volume five to zero, bit seven zero.
// - MIDI mask ANDs the MIDI request; reset clears the mask.
// - Read-only bit shows pending hardware volume request.
// - Volume mask gates request before OR into first audio request.
// - Legacy volume writes go to both counters unless disabled.
// - A write to the clear register drops the pending volume request unless a new event arrives in the same cycle.
// - Registers are reached by index port then data port.
`include "smv_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module smv_serial_regs (
	input  wire        i_clk,
	input  wire        i_reset_n,
	// Host index/data ports
	input  wire        i_port_sel,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire [7:0]  i_wdata,
	output reg  [7:0]  o_rdata,
	// Legacy master volume write strobe
	input  wire        i_legacy_vol_wr,
	input  wire [7:0]  i_legacy_vol_data,
	// Interrupt sources
	input  wire        i_hardware_volume_event,
	input  wire        i_midi_irq,
	input  wire        i_audio1_irq,
	output wire        o_midi_irq,
	output wire        o_audio1_irq,
	// Pins
	input  wire        i_serial_mode_select_pin,
	input  wire        i_serial_clk_pin,
	input  wire        i_receive_frame_sync,
	input  wire        i_transmit_frame_sync,
	input  wire        i_serial_rx_data_pin,
	output reg         o_serial_tx_data_pin,
	input  wire        i_ext_synth_clk_pin,
	input  wire        i_ext_synth_data_pin,
	// Analog and mixer controls
	output wire        o_serial_mode,
	output wire        o_out_volume_override,
	output wire [3:0]  o_out_volume,
	output reg  [2:0]  o_speaker_src,
	output wire        o_analog_override,
	output wire        o_left_adc_mode,
	output wire        o_right_adc_mode,
	output wire        o_analog_route_bit_high,
	output wire        o_analog_route_bit_low,
	output wire        o_duplex_analog_output_en,
	output wire        o_duplex_analog_input_en,
	output wire        o_ext_synth_owns_fm,
	output reg         o_filter_clk_en,
	output wire [5:0]  o_left_master_vol,
	output wire        o_left_master_mute,
	output wire [5:0]  o_right_master_vol,
	output wire        o_right_master_mute,
	// Transmit sources
	input  wire [15:0] i_tx_fifo_data,
	input  wire [15:0] i_left_adc_data,
	input  wire [15:0] i_right_adc_data,
	output reg         o_tx_load,
	// Received words
	output reg  [15:0] o_rx_left_data,
	output reg  [15:0] o_rx_right_data,
	output reg         o_rx_valid,
	output reg  [1:0]  o_rx_target
);

	// ==========================================================
	// Helpers

	// Bits in a serial word
	function [4:0] word_len;
		input long_word;
		begin
			word_len = long_word ? `SMV_WORD_LONG : `SMV_WORD_SHORT;
		end
	endfunction

	// Toggle the sign bit between unsigned and two's complement
	function [15:0] fix_format;
		input [15:0] w;
		input        twos;
		begin
			fix_format = twos ? w : {~w[15], w[14:0]};
		end
	endfunction

	// ==========================================================
	// Reset release

	reg        rst_s1_q;
	reg        rst_n_q;

	// Asynchronous assert, synchronous release
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ==========================================================
	// Pin synchronisers

	wire [6:0] pins_raw = {i_ext_synth_data_pin, i_ext_synth_clk_pin, i_serial_rx_data_pin,
		i_transmit_frame_sync, i_receive_frame_sync, i_serial_clk_pin, i_serial_mode_select_pin};
	reg  [6:0] pins_s1_q;
	reg  [6:0] pins_s2_q;
	reg  [6:0] pins_s3_q;

	// Two flops, plus a third for edge detection
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pins_s1_q <= 7'h00;
			pins_s2_q <= 7'h00;
			pins_s3_q <= 7'h00;
		end else begin
			pins_s1_q <= pins_raw;
			pins_s2_q <= pins_s1_q;
			pins_s3_q <= pins_s2_q;
		end
	end

	wire se_pin   = pins_s2_q[0];
	wire sclk_r   = pins_s2_q[1] & ~pins_s3_q[1];
	wire fsr_pin  = pins_s2_q[2];
	wire fsx_pin  = pins_s2_q[3];
	wire rxd_pin  = pins_s2_q[4];
	wire synth_act = (pins_s2_q[5] ^ pins_s3_q[5]) | (pins_s2_q[6] ^ pins_s3_q[6]);

	// ==========================================================
	// Register file

	reg [7:0] index_q;
	reg [7:0] out_ctrl_q;
	reg [6:0] analog_q;
	reg [4:0] misc_q;
	reg [4:0] filt_q;
	reg [7:0] format_q;
	reg [6:0] left_vol_q;
	reg [6:0] right_vol_q;
	reg [2:0] vol_ctrl_q;
	reg       hv_pend_q;

	wire data_wr = i_wr && (i_port_sel == `SMV_PORT_DATA);
	wire legacy_ok = i_legacy_vol_wr && !vol_ctrl_q[`SMV_VC_LEGDIS_BIT];
	wire clr_wr = data_wr && (index_q == `SMV_IDX_VOL_CLEAR);

	// Index latch and data writes
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			index_q     <= `SMV_RESET_BYTE;
			out_ctrl_q  <= `SMV_RESET_BYTE;
			analog_q    <= 7'h00;
			misc_q      <= 5'h00;
			filt_q      <= 5'h00;
			format_q    <= `SMV_RESET_BYTE;
			left_vol_q  <= 7'h00;
			right_vol_q <= 7'h00;
			vol_ctrl_q  <= 3'h0;
		end else begin
			if (i_wr && (i_port_sel == `SMV_PORT_INDEX)) begin
				index_q <= i_wdata;
			end
			if (legacy_ok) begin
				left_vol_q  <= {1'b0, i_legacy_vol_data[7:4], i_legacy_vol_data[7:6]};
				right_vol_q <= {1'b0, i_legacy_vol_data[3:0], i_legacy_vol_data[3:2]};
			end
			if (data_wr) begin
				case (index_q)
				`SMV_IDX_OUT_CTRL:  out_ctrl_q  <= i_wdata;
				`SMV_IDX_ANALOG:    analog_q    <= {1'b0, i_wdata[5:0]};
				`SMV_IDX_MISC:      misc_q      <= i_wdata[7:3];
				`SMV_IDX_FILT_DIV:  filt_q      <= {i_wdata[7], i_wdata[3:0]};
				`SMV_IDX_FORMAT:    format_q    <= i_wdata;
				`SMV_IDX_LEFT_VOL:  left_vol_q  <= i_wdata[6:0];
				`SMV_IDX_RIGHT_VOL: right_vol_q <= i_wdata[6:0];
				`SMV_IDX_VOL_CTRL:  vol_ctrl_q  <= {i_wdata[6], i_wdata[1:0]};
				default:            ;
				endcase
			end
		end
	end

	// Analog override bit kept apart from the low seven bits
	reg analog_ovr_q;
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			analog_ovr_q <= 1'b0;
		end else if (data_wr && (index_q == `SMV_IDX_ANALOG)) begin
			analog_ovr_q <= i_wdata[`SMV_ANA_OVR_BIT];
		end
	end

	// Pending volume request; a new event beats a clear
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			hv_pend_q <= 1'b0;
		end else if (i_hardware_volume_event) begin
			hv_pend_q <= 1'b1;
		end else if (clr_wr) begin
			hv_pend_q <= 1'b0;
		end
	end

	// Read data, one cycle after the read strobe
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_rdata <= `SMV_RESET_BYTE;
		end else if (i_rd) begin
			if (i_port_sel == `SMV_PORT_INDEX) begin
				o_rdata <= index_q;
			end else begin
				case (index_q)
				`SMV_IDX_OUT_CTRL:  o_rdata <= out_ctrl_q;
				`SMV_IDX_ANALOG:    o_rdata <= {analog_ovr_q, analog_q};
				`SMV_IDX_MISC:      o_rdata <= {misc_q, 3'h0};
				`SMV_IDX_FILT_DIV:  o_rdata <= {filt_q[4], 3'h0, filt_q[3:0]};
				`SMV_IDX_FORMAT:    o_rdata <= format_q;
				`SMV_IDX_LEFT_VOL:  o_rdata <= {1'b0, left_vol_q};
				`SMV_IDX_RIGHT_VOL: o_rdata <= {1'b0, right_vol_q};
				`SMV_IDX_VOL_CTRL:  o_rdata <= {1'b0, vol_ctrl_q[2], 1'b0, hv_pend_q,
					2'h0, vol_ctrl_q[1:0]};
				default:            o_rdata <= `SMV_RESET_BYTE;
				endcase
			end
		end
	end

	// ==========================================================
	// Mode and analog controls

	wire serial_mode = misc_q[4] | se_pin;
	wire twos        = misc_q[3];
	wire srst        = misc_q[2];
	wire polarity    = misc_q[0];
	wire ana_on      = analog_ovr_q & serial_mode;

	assign o_serial_mode         = serial_mode;
	assign o_out_volume_override = out_ctrl_q[`SMV_OUT_OVR_BIT] & serial_mode;
	assign o_out_volume          = out_ctrl_q[3:0];
	assign o_analog_override     = ana_on;
	assign o_left_adc_mode       = ana_on & analog_q[`SMV_ANA_LADC_BIT];
	assign o_right_adc_mode      = ana_on & analog_q[`SMV_ANA_RADC_BIT];
	assign o_analog_route_bit_high = ana_on & analog_q[3];
	assign o_analog_route_bit_low  = ana_on & analog_q[2];
	assign o_duplex_analog_output_en = ana_on & analog_q[`SMV_ANA_DXO_BIT] & ~srst;
	assign o_duplex_analog_input_en  = ana_on & analog_q[`SMV_ANA_DXI_BIT];

	assign o_left_master_vol   = left_vol_q[5:0];
	assign o_left_master_mute  = left_vol_q[6];
	assign o_right_master_vol  = right_vol_q[5:0];
	assign o_right_master_mute = right_vol_q[6];

	// Interrupt gating
	assign o_midi_irq   = i_midi_irq & vol_ctrl_q[2];
	assign o_audio1_irq = i_audio1_irq | (hv_pend_q & vol_ctrl_q[1]);

	// Speaker source, reserved code forced to mute
	always @* begin
		o_speaker_src = out_ctrl_q[6:4];
		if (out_ctrl_q[6:4] == `SMV_SPK_RESERVED) begin
			o_speaker_src = `SMV_SPK_MUTE;
		end
	end

	// ==========================================================
	// External synthesizer acquisition

	reg synth_q;
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			synth_q <= 1'b0;
		end else if (!misc_q[1]) begin
			synth_q <= 1'b0;
		end else if (synth_act) begin
			synth_q <= 1'b1;
		end
	end
	assign o_ext_synth_owns_fm = synth_q;

	// ==========================================================
	// Filter clock divider

	reg  [4:0] fdiv_q;
	wire [4:0] fdiv_n = `SMV_DIV_BASE - {1'b0, filt_q[3:0]};
	wire       fdiv_on = filt_q[4] & serial_mode;

	// One pulse per divisor count of serial clock edges
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fdiv_q          <= 5'h00;
			o_filter_clk_en <= 1'b0;
		end else begin
			o_filter_clk_en <= 1'b0;
			if (!fdiv_on) begin
				fdiv_q <= 5'h00;
			end else if (sclk_r) begin
				if (fdiv_q + 5'h01 >= fdiv_n) begin
					fdiv_q          <= 5'h00;
					o_filter_clk_en <= 1'b1;
				end else begin
					fdiv_q <= fdiv_q + 5'h01;
				end
			end
		end
	end

	// ==========================================================
	// Receive framing

	wire       fsr_act = fsr_pin ^ polarity;
	wire       fsx_act = fsx_pin ^ polarity;
	wire [1:0] rx_tgt  = format_q[3:2];
	wire       rx_long = format_q[`SMV_FMT_RXLEN_BIT];
	wire       rx_st   = format_q[`SMV_FMT_RXST_BIT];
	reg [15:0] rx_sh_q;
	reg [4:0]  rx_cnt_q;
	reg        rx_busy_q;
	reg        rx_right_q;
	wire [15:0] rx_word = rx_long ? {rx_sh_q[14:0], rxd_pin} : {rx_sh_q[6:0], rxd_pin, 8'h00};
	wire [15:0] rx_fix  = fix_format(rx_word, twos);

	// Shift in MSB first, deliver at word end
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_sh_q         <= 16'h0000;
			rx_cnt_q        <= 5'h00;
			rx_busy_q       <= 1'b0;
			rx_right_q      <= 1'b0;
			o_rx_valid      <= 1'b0;
			o_rx_target     <= `SMV_SRC_NONE;
			o_rx_left_data  <= 16'h0000;
			o_rx_right_data <= 16'h0000;
		end else begin
			o_rx_valid <= 1'b0;
			if (srst) begin
				rx_sh_q    <= 16'h0000;
				rx_cnt_q   <= 5'h00;
				rx_busy_q  <= 1'b0;
				rx_right_q <= 1'b0;
			end else if (sclk_r) begin
				if (rx_busy_q) begin
					rx_sh_q  <= {rx_sh_q[14:0], rxd_pin};
					rx_cnt_q <= rx_cnt_q + 5'h01;
					if (rx_cnt_q + 5'h01 == word_len(rx_long)) begin
						rx_busy_q <= 1'b0;
						rx_sh_q   <= 16'h0000;
						if (rx_tgt != `SMV_SRC_NONE) begin
							o_rx_valid  <= 1'b1;
							o_rx_target <= rx_tgt;
							if (rx_st) begin
								rx_right_q <= ~rx_right_q;
								if (rx_right_q) begin
									o_rx_right_data <= rx_fix;
								end else begin
									o_rx_left_data <= rx_fix;
								end
							end else begin
								o_rx_right_data <= rx_fix;
								o_rx_left_data  <= ~rx_fix;
							end
						end
					end
				end else if (fsr_act) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q  <= 5'h00;
				end
			end
		end
	end

	// ==========================================================
	// Transmit framing

	wire [1:0] tx_src  = format_q[7:6];
	wire       tx_long = format_q[`SMV_FMT_TXLEN_BIT];
	wire       tx_st   = format_q[`SMV_FMT_TXST_BIT];
	reg [15:0] tx_sh_q;
	reg [4:0]  tx_cnt_q;
	reg        tx_busy_q;
	reg        tx_right_q;
	reg [15:0] tx_pick;

	// Source selection for the next word
	always @* begin
		case (tx_src)
		`SMV_SRC_FIFO:  tx_pick = i_tx_fifo_data;
		`SMV_SRC_LEFT:  tx_pick = (tx_st && tx_right_q) ? i_right_adc_data : i_left_adc_data;
		`SMV_SRC_RIGHT: tx_pick = i_right_adc_data;
		default:        tx_pick = 16'h0000;
		endcase
	end

	// Load on sync, shift out MSB first
	always @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_sh_q              <= 16'h0000;
			tx_cnt_q             <= 5'h00;
			tx_busy_q            <= 1'b0;
			tx_right_q           <= 1'b0;
			o_tx_load            <= 1'b0;
			o_serial_tx_data_pin <= 1'b0;
		end else begin
			o_tx_load <= 1'b0;
			if (srst) begin
				tx_sh_q              <= 16'h0000;
				tx_cnt_q             <= 5'h00;
				tx_busy_q            <= 1'b0;
				tx_right_q           <= 1'b0;
				o_serial_tx_data_pin <= 1'b0;
			end else if (sclk_r) begin
				if (tx_busy_q) begin
					o_serial_tx_data_pin <= tx_sh_q[15];
					tx_sh_q              <= {tx_sh_q[14:0], 1'b0};
					tx_cnt_q             <= tx_cnt_q + 5'h01;
					if (tx_cnt_q + 5'h01 == word_len(tx_long)) begin
						tx_busy_q <= 1'b0;
					end
				end else if (fsx_act) begin
					tx_busy_q <= 1'b1;
					tx_cnt_q  <= 5'h00;
					o_tx_load <= (tx_src != `SMV_SRC_NONE);
					tx_sh_q   <= (tx_src == `SMV_SRC_NONE) ? 16'h0000 : fix_format(tx_pick, twos);
					if (tx_st) begin
						tx_right_q <= ~tx_right_q;
					end
				end
			end
		end
	end

endmodule // smv_serial_regs

`default_nettype wire

// ---- core/smv_regs.vh ----
// Purpose: Offsets, fields, reset values and counts for the serial mode
//          and master volume register bank.
// Assumes: Registers are 8 bits wide and reached through index/data ports.
// Notes:   Definitions only.
`ifndef SMV_REGS_VH
`define SMV_REGS_VH

// ==========================================================
// Host port selects
`define SMV_PORT_INDEX      1'b0
`define SMV_PORT_DATA       1'b1

// ==========================================================
// Register indices
`define SMV_IDX_OUT_CTRL    8'h44
`define SMV_IDX_ANALOG      8'h46
`define SMV_IDX_MISC        8'h48
`define SMV_IDX_FILT_DIV    8'h4c
`define SMV_IDX_FORMAT      8'h4e
`define SMV_IDX_LEFT_VOL    8'h60
`define SMV_IDX_RIGHT_VOL   8'h62
`define SMV_IDX_VOL_CTRL    8'h64
`define SMV_IDX_VOL_CLEAR   8'h66

// ==========================================================
// Field positions
`define SMV_OUT_OVR_BIT     7
`define SMV_ANA_OVR_BIT     7
`define SMV_ANA_LADC_BIT    5
`define SMV_ANA_RADC_BIT    4
`define SMV_ANA_DXO_BIT     1
`define SMV_ANA_DXI_BIT     0
`define SMV_MISC_FORCE_BIT  7
`define SMV_MISC_2COMP_BIT  6
`define SMV_MISC_SRST_BIT   5
`define SMV_MISC_SYNTH_BIT  4
`define SMV_MISC_POL_BIT    3
`define SMV_FILT_OVR_BIT    7
`define SMV_FMT_TXLEN_BIT   5
`define SMV_FMT_TXST_BIT    4
`define SMV_FMT_RXLEN_BIT   1
`define SMV_FMT_RXST_BIT    0
`define SMV_VC_MIDI_BIT     6
`define SMV_VC_HVMASK_BIT   1
`define SMV_VC_LEGDIS_BIT   0

// ==========================================================
// Reset values and codes
`define SMV_RESET_BYTE      8'h00
`define SMV_SPK_MUTE        3'h0
`define SMV_SPK_RESERVED    3'h7
`define SMV_SRC_NONE        2'h0
`define SMV_SRC_FIFO        2'h1
`define SMV_SRC_LEFT        2'h2
`define SMV_SRC_RIGHT       2'h3
`define SMV_WORD_LONG       5'h10
`define SMV_WORD_SHORT      5'h08
`define SMV_DIV_BASE        5'h10

`endif

// ---- verification/smv_regs_chk.sv ----
// Purpose: Port assertions for the serial mode register bank.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module smv_regs_chk (
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_midi_irq,
	input wire logic       o_midi_irq,
	input wire logic       i_audio1_irq,
	input wire logic       o_audio1_irq,
	input wire logic       i_serial_mode_select_pin,
	input wire logic       o_serial_mode,
	input wire logic       o_out_volume_override,
	input wire logic [2:0] o_speaker_src,
	input wire logic       o_analog_override,
	input wire logic       o_left_adc_mode,
	input wire logic       o_right_adc_mode,
	input wire logic       o_duplex_analog_output_en,
	input wire logic       o_filter_clk_en,
	input wire logic       o_rx_valid,
	input wire logic [1:0] o_rx_target
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Interrupt gating
	AST_MIDI_GATE: assert property (o_midi_irq |-> i_midi_irq)
		else $error("midi request passed while input low");
	AST_AUDIO_PASS: assert property (i_audio1_irq |-> o_audio1_irq)
		else $error("audio request not passed through");
	// Serial mode gating of overrides, reserved speaker code and serial mode from the pin
	AST_OUT_OVR: assert property (o_out_volume_override |-> o_serial_mode)
		else $error("volume override outside serial mode");
	AST_SPK_CODE: assert property (o_speaker_src != 3'h7)
		else $error("reserved speaker code not muted");
	AST_ANA_GATE: assert property ((o_left_adc_mode || o_right_adc_mode || o_duplex_analog_output_en)
		|-> o_analog_override)
		else $error("analog bit active without override");
	AST_ANA_SERIAL: assert property (o_analog_override |-> o_serial_mode)
		else $error("analog override outside serial mode");
	AST_PIN_MODE: assert property (i_serial_mode_select_pin [*8] |-> o_serial_mode)
		else $error("serial mode does not follow pin");
	// Link and host bus
	AST_RX_TARGET: assert property (o_rx_valid |-> o_rx_target != 2'h0)
		else $error("word delivered with no target");
	AST_RDATA_HOLD: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data moved without a read");
	AST_FILT_PULSE: assert property (o_filter_clk_en |=> !o_filter_clk_en)
		else $error("filter clock pulse too long");
endmodule // smv_regs_chk

bind smv_serial_regs smv_regs_chk u_chk (.i_clk, .i_reset_n, .i_rd, .o_rdata, .i_midi_irq, .o_midi_irq,
	.i_audio1_irq, .o_audio1_irq, .i_serial_mode_select_pin, .o_serial_mode, .o_out_volume_override,
	.o_speaker_src, .o_analog_override, .o_left_adc_mode, .o_right_adc_mode, .o_duplex_analog_output_en,
	.o_filter_clk_en, .o_rx_valid, .o_rx_target);
`default_nettype wire

// ---- verification/smv_dsp_model.sv ----
// Purpose: External DSP on the serial link.
// Assumes: Serial clock period 200 ns, still between frames.
// Notes:   Data launched on falls, captured on rises.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// DSP model
module smv_dsp_model (
	input  wire logic i_pol,
	input  wire logic i_tx_data,
	output var  logic o_sclk,
	output var  logic o_fsr,
	output var  logic o_fsx,
	output var  logic o_rx_data
);
	// Idle link
	initial begin
		o_sclk = 1'b0;
		o_fsr = 1'b0;
		o_fsx = 1'b0;
		o_rx_data = 1'b0;
	end

	// One framed word each way; capture lags launch by one rise
	task automatic xfer(input int len, input logic [15:0] w, output logic [15:0] got);
		int k;
		got = 16'h0000;
		#100;
		o_fsr = ~i_pol;
		o_fsx = ~i_pol;
		for (k = 0; k <= len + 1; k++) begin
			#100 o_sclk = 1'b1;
			if (k >= 2) got = {got[14:0], i_tx_data};
			#100 o_sclk = 1'b0;
			o_fsr = i_pol;
			o_fsx = i_pol;
			o_rx_data = (k < len) ? w[15 - k] : ~o_rx_data;
		end
	endtask
endmodule // smv_dsp_model
`default_nettype wire

// ---- verification/tb_serial_mode_and_master_volume_regs.sv ----
// Purpose: Self-checking bench for the serial mode register bank.
// Assumes: Inputs change 2 ns after the rising clock edge.
// Notes:   The DSP model frames serial words on request.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top
module tb_serial_mode_and_master_volume_regs;
	logic        i_clk, i_reset_n, i_port_sel, i_wr, i_rd, i_legacy_vol_wr, i_hardware_volume_event, pol;
	logic        i_midi_irq, i_audio1_irq, i_serial_mode_select_pin, i_ext_synth_clk_pin, i_ext_synth_data_pin;
	logic [7:0]  i_wdata, i_legacy_vol_data, rv;
	logic [15:0] i_tx_fifo_data, i_left_adc_data, i_right_adc_data, got;
	wire         i_serial_clk_pin, i_receive_frame_sync, i_transmit_frame_sync, i_serial_rx_data_pin;
	wire         o_midi_irq, o_audio1_irq, o_serial_tx_data_pin, o_serial_mode, o_out_volume_override;
	wire         o_analog_override, o_left_adc_mode, o_right_adc_mode, o_analog_route_bit_high;
	wire         o_analog_route_bit_low, o_duplex_analog_output_en, o_duplex_analog_input_en;
	wire         o_ext_synth_owns_fm, o_filter_clk_en, o_left_master_mute, o_right_master_mute, o_tx_load, o_rx_valid;
	wire [7:0]   o_rdata;
	wire [3:0]   o_out_volume;
	wire [2:0]   o_speaker_src;
	wire [5:0]   o_left_master_vol, o_right_master_vol;
	wire [15:0]  o_rx_left_data, o_rx_right_data;
	wire [1:0]   o_rx_target;
	int          bad_count, n_compared, rx_n, filt_n, tx_n, n0, n1, n2;
	logic [7:0]  idx [10] = '{8'h44, 8'h46, 8'h48, 8'h4c, 8'h4e, 8'h60, 8'h62, 8'h64, 8'h66, 8'h50};
	logic [7:0]  msk [10] = '{8'hff, 8'hbf, 8'hf8, 8'h8f, 8'hff, 8'h7f, 8'h7f, 8'h43, 8'h00, 8'h00};

	smv_serial_regs uut (.*);
	smv_dsp_model dsp (.i_pol(pol), .i_tx_data(o_serial_tx_data_pin), .o_sclk(i_serial_clk_pin),
		.o_fsr(i_receive_frame_sync), .o_fsx(i_transmit_frame_sync), .o_rx_data(i_serial_rx_data_pin));

	// Clock and pulse counters
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (o_rx_valid === 1'b1) rx_n <= rx_n + 1;
		if (o_filter_clk_en === 1'b1) filt_n <= filt_n + 1;
		if (o_tx_load === 1'b1) tx_n <= tx_n + 1;
	end

	// ==========================================================
	// Helpers
	task automatic tick;
		@(posedge i_clk);
		#2;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick;
		{i_port_sel, i_wr, i_wdata} = {2'b01, a};
		tick;
		{i_port_sel, i_wdata} = {1'b1, d};
		tick;
		i_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		tick;
		{i_port_sel, i_wr, i_wdata} = {2'b01, a};
		tick;
		{i_port_sel, i_wr, i_rd} = 3'b101;
		tick;
		i_rd = 0;
		d = o_rdata;
	endtask
	task automatic legacy(input logic [7:0] d);
		tick;
		{i_legacy_vol_wr, i_legacy_vol_data} = {1'b1, d};
		tick;
		i_legacy_vol_wr = 0;
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		int j;
		for (j = 0; j < 10; j++) begin
			rd(idx[j], rv);
			chk(rv, 8'h00);
		end
		for (j = 0; j < 10; j++) wr(idx[j], 8'hff);
		for (j = 0; j < 10; j++) begin
			rd(idx[j], rv);
			chk(rv, msk[j]);
		end
		chk({o_out_volume_override, o_out_volume}, 5'h1f);
		chk(o_speaker_src, 3'h0);
		chk({o_analog_route_bit_high, o_duplex_analog_output_en}, 2'h2);
		chk({o_left_master_mute, o_left_master_vol}, 7'h7f);
		wr(8'h48, 8'h80);
		chk(o_duplex_analog_output_en, 1);
		for (j = 0; j < 8; j++) wr(idx[j], 8'h00);
		fin("regs");
	endtask
	task automatic t_spk;
		int c;
		for (c = 0; c < 8; c++) begin
			wr(8'h44, 8'(c << 4));
			chk(o_speaker_src, (c == 7) ? 3'h0 : 3'(c));
		end
		fin("speaker");
	endtask
	task automatic t_analog;
		wr(8'h48, 8'h80);
		wr(8'h46, 8'h3f);
		chk({o_analog_override, o_left_adc_mode, o_duplex_analog_input_en}, 0);
		wr(8'h46, 8'ha0);
		chk({o_left_adc_mode, o_right_adc_mode}, 2'h2);
		wr(8'h46, 8'h9b);
		chk({o_left_adc_mode, o_right_adc_mode, o_analog_route_bit_high, o_analog_route_bit_low,
			o_duplex_analog_output_en, o_duplex_analog_input_en}, 6'h1b);
		wr(8'h48, 8'h00);
		chk({o_serial_mode, o_analog_override}, 0);
		i_serial_mode_select_pin = 1;
		repeat (8) tick;
		chk(o_serial_mode, 1);
		i_serial_mode_select_pin = 0;
		wr(8'h46, 8'h00);
		fin("analog");
	endtask
	task automatic t_irq;
		tick;
		i_midi_irq = 1;
		#1 chk(o_midi_irq, 0);
		wr(8'h64, 8'h40);
		chk(o_midi_irq, 1);
		i_hardware_volume_event = 1;
		tick;
		{i_hardware_volume_event, i_midi_irq} = 2'b00;
		tick;
		chk(o_audio1_irq, 0);
		rd(8'h64, rv);
		chk(rv, 8'h50);
		wr(8'h64, 8'h02);
		chk(o_audio1_irq, 1);
		wr(8'h66, 8'h5a);
		rd(8'h64, rv);
		chk({rv, 7'h00, o_audio1_irq}, 16'h0200);
		i_audio1_irq = 1;
		#1 chk(o_audio1_irq, 1);
		tick;
		i_audio1_irq = 0;
		fin("irq");
	endtask
	task automatic t_legacy;
		wr(8'h64, 8'h00);
		wr(8'h60, 8'h40);
		legacy(8'h9c);
		rd(8'h60, rv);
		chk(rv, 8'h26);
		rd(8'h62, rv);
		chk(rv, 8'h33);
		chk({o_right_master_mute, o_right_master_vol}, 7'h33);
		wr(8'h64, 8'h01);
		legacy(8'h11);
		rd(8'h60, rv);
		chk(rv, 8'h26);
		fin("legacy");
	endtask
	task automatic t_synth;
		int j;
		for (j = 0; j < 3; j++) begin
			wr(8'h48, (j == 1) ? 8'h90 : 8'h80);
			i_ext_synth_clk_pin = ~i_ext_synth_clk_pin;
			repeat (6) tick;
			chk(o_ext_synth_owns_fm, (j == 1));
		end
		fin("synth");
	endtask
	task automatic t_ser_a;
		wr(8'h48, 8'h80);
		wr(8'h4e, 8'h88);
		i_left_adc_data = 16'h3c00;
		n0 = rx_n;
		dsp.xfer(8, 16'ha500, got);
		chk(got[7:0], 8'hbc);
		chk(rx_n - n0, 1);
		chk(o_rx_right_data, 16'h2500);
		chk(o_rx_left_data, 16'hdaff);
		chk(o_rx_target, 2'h2);
		fin("serial mono");
	endtask
	task automatic t_ser_b;
		pol = 1;
		wr(8'h48, 8'he8);
		wr(8'h48, 8'hc8);
		wr(8'h4e, 8'hef);
		i_right_adc_data = 16'h8123;
		{n0, n1} = {rx_n, tx_n};
		dsp.xfer(16, 16'h1234, got);
		chk(got, 16'h8123);
		chk(o_rx_left_data, 16'h1234);
		dsp.xfer(16, 16'hfedc, got);
		chk(got, 16'h8123);
		chk(o_rx_right_data, 16'hfedc);
		chk(rx_n - n0, 2);
		chk(o_rx_target, 2'h3);
		chk(tx_n - n1, 2);
		fin("serial stereo");
	endtask
	task automatic t_filt;
		pol = 0;
		wr(8'h48, 8'h80);
		wr(8'h4e, 8'h44);
		wr(8'h4c, 8'h8e);
		i_tx_fifo_data = 16'h5a00;
		n0 = filt_n;
		dsp.xfer(8, 16'h1200, got);
		chk(filt_n - n0, 5);
		chk(got[7:0], 8'hda);
		chk(o_rx_right_data, 16'h9200);
		chk(o_rx_left_data, 16'h6dff);
		chk(o_rx_target, 2'h1);
		wr(8'h4c, 8'h0e);
		wr(8'h4e, 8'h00);
		{n0, n1, n2} = {filt_n, tx_n, rx_n};
		dsp.xfer(8, 16'h0000, got);
		chk(filt_n - n0, 0);
		chk(tx_n - n1, 0);
		chk(rx_n - n2, 0);
		chk(got, 16'h0000);
		fin("filter");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		i_clk = 0;
		{i_reset_n, i_port_sel, i_wr, i_rd, i_legacy_vol_wr, i_hardware_volume_event, pol} = 0;
		{i_midi_irq, i_audio1_irq, i_serial_mode_select_pin, i_ext_synth_clk_pin, i_ext_synth_data_pin} = 0;
		{i_wdata, i_legacy_vol_data, i_tx_fifo_data, i_left_adc_data, i_right_adc_data} = 0;
		repeat (8) @(posedge i_clk);
		#2 i_reset_n = 1;
		repeat (4) tick;
		t_regs;
		t_spk;
		t_analog;
		t_irq;
		t_legacy;
		t_synth;
		t_ser_a;
		t_ser_b;
		t_filt;
		wrap_up;
	end
	initial begin
		#2000000;
		bad_count++;
		wrap_up;
	end
endmodule // tb_serial_mode_and_master_volume_regs
`default_nettype wire
